//--- rtl/nbl_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
// Request/answer link between sequencer and bus-cycle engine
interface nbl_cyc_if;
	logic req;
	logic is_cmd;
	logic is_read;
	logic [7:0] wdata;
	logic done;
	logic [7:0] rdata;
	modport seq (output req, output is_cmd, output is_read, output wdata, input done, input rdata);
	modport eng (input req, input is_cmd, input is_read, input wdata, output done, output rdata);
endinterface : nbl_cyc_if
`default_nettype wire

//--- rtl/nbl_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// Drives one command, address or read cycle on the flash bus
module nbl_cycle (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	nbl_cyc_if.eng cyc, // Cycle requests
	input wire logic [7:0] io_sync, // Synchronised I/O
	output logic cle_q, // Command latch
	output logic ale_q, // Address latch
	output logic we_n_q, // Write enable
	output logic re_n_q, // Read enable
	output logic [7:0] io_out_q, // I/O data out
	output logic io_oe_q // I/O drive enable
);
	typedef enum logic [2:0] {
		CY_IDLE = 3'b001,
		CY_LOW = 3'b010,
		CY_HIGH = 3'b100
	} nbl_cy_t;
	nbl_cy_t st_q;
	logic [3:0] cnt_q;
	logic rd_q;
	logic [7:0] rdata_q;
	logic done_q;
	assign cyc.done = done_q;
	assign cyc.rdata = rdata_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= CY_IDLE;
			cnt_q <= 4'h0;
			rd_q <= 1'b0;
			done_q <= 1'b0;
			rdata_q <= 8'h00;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			we_n_q <= 1'b1;
			re_n_q <= 1'b1;
			io_out_q <= 8'h00;
			io_oe_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				CY_IDLE: begin
					if (cyc.req) begin
						rd_q <= cyc.is_read;
						cle_q <= cyc.is_cmd & ~cyc.is_read;
						ale_q <= ~cyc.is_cmd & ~cyc.is_read;
						we_n_q <= cyc.is_read;
						re_n_q <= ~cyc.is_read;
						io_out_q <= cyc.wdata;
						io_oe_q <= ~cyc.is_read;
						cnt_q <= 4'(nbl_pkg::STROBE_CYC);
						st_q <= CY_LOW;
					end
				end
				CY_LOW: begin
					if (cnt_q == 4'h1) begin
						we_n_q <= 1'b1;
						re_n_q <= 1'b1;
						cnt_q <= 4'(nbl_pkg::STROBE_CYC);
						st_q <= CY_HIGH;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				CY_HIGH: begin
					// Synchroniser lags two edges: the byte sampled while read enable was low arrives here
					if (rd_q && cnt_q == 4'(nbl_pkg::STROBE_CYC)) begin
						rdata_q <= io_sync;
					end
					if (cnt_q == 4'h1) begin
						cle_q <= 1'b0;
						ale_q <= 1'b0;
						io_oe_q <= 1'b0;
						done_q <= 1'b1;
						st_q <= CY_IDLE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				default: st_q <= CY_IDLE;
			endcase
		end
	end
endmodule // nbl_cycle
`default_nettype wire

//--- rtl/nbl_host.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Hold write protect low over power transitions
// - Unlock: setup, start address, confirm, end address
// - Block address: three or two cycles
// - Start address not above end address
// - Status query: command, address, then one read
module nbl_host #(
	parameter int ADDR_CYCLES = nbl_pkg::ADDR_CYC_BIG
) (
	input wire logic CLK, // Clock
	input wire logic RESETN, // Async reset, active low
	input wire logic REQ_VALID, // Operation request
	input wire logic [2:0] REQ_OP, // Operation code
	input wire logic [23:0] REQ_START, // Start or query block address
	input wire logic [23:0] REQ_END, // End block address
	output logic REQ_READY, // Idle, accepts a request
	output logic DONE, // Operation finished pulse
	output logic ERR, // Request refused
	output logic [2:0] LOCK_STATUS, // Last lock status code
	output logic LOCK_EN, // Lock feature enable pin
	output logic WP_N, // Write protect pin
	output logic CE_N, // Chip enable
	output logic CLE, // Command latch enable
	output logic ALE, // Address latch enable
	output logic WE_N, // Write enable
	output logic RE_N, // Read enable
	output logic [7:0] IO_OUT, // I/O data out
	output logic IO_OE, // I/O drive enable
	input wire logic [7:0] IO_IN, // I/O data in
	input wire logic DEVICE_READY_N // Ready/busy pin, low busy
);
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_ISSUE = 5'b00010,
		S_WAIT = 5'b00100,
		S_WPLOW = 5'b01000,
		S_END = 5'b10000
	} nbl_st_t;
	nbl_cyc_if cyc ();
	nbl_st_t st_q;
	logic [7:0] io_m_q, io_s_q;
	logic rb_m_q, rb_s_q;
	logic [2:0] op_q;
	logic [23:0] sa_q, ea_q;
	logic [3:0] step_q, nsteps_q;
	logic [3:0] wcnt_q;
	logic req_q, is_cmd_q, is_read_q;
	logic [7:0] wdata_q;
	logic cle_w, ale_w, we_w, re_w, oe_w;
	logic [7:0] out_w;
	logic [3:0] ai;
	logic [23:0] addr_sel;
	assign cyc.req = req_q;
	assign cyc.is_cmd = is_cmd_q;
	assign cyc.is_read = is_read_q;
	assign cyc.wdata = wdata_q;

	nbl_cycle u_cyc (
		.clk(CLK),
		.rst_n(RESETN),
		.cyc(cyc),
		.io_sync(io_s_q),
		.cle_q(cle_w),
		.ale_q(ale_w),
		.we_n_q(we_w),
		.re_n_q(re_w),
		.io_out_q(out_w),
		.io_oe_q(oe_w)
	);
	assign CLE = cle_w;
	assign ALE = ale_w;
	assign WE_N = we_w;
	assign RE_N = re_w;
	assign IO_OUT = out_w;
	assign IO_OE = oe_w;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			io_m_q <= 8'h00;
			io_s_q <= 8'h00;
			rb_m_q <= 1'b0;
			rb_s_q <= 1'b0;
		end else begin
			io_m_q <= IO_IN;
			io_s_q <= io_m_q;
			rb_m_q <= DEVICE_READY_N;
			rb_s_q <= rb_m_q;
		end
	end

	// Step byte: each step is a command, an address byte or a read
	always_comb begin
		addr_sel = sa_q;
		ai = 4'h0;
		case (op_q)
			3'(nbl_pkg::NBL_OP_UNLOCK): begin
				if (step_q > 4'(ADDR_CYCLES)) begin
					addr_sel = ea_q;
					ai = step_q - 4'(ADDR_CYCLES) - 4'h2;
				end else begin
					ai = step_q - 4'h1;
				end
			end
			default: ai = step_q - 4'h1;
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_q <= S_IDLE;
			op_q <= 3'h0;
			sa_q <= 24'h00_0000;
			ea_q <= 24'h00_0000;
			step_q <= 4'h0;
			nsteps_q <= 4'h0;
			wcnt_q <= 4'h0;
			req_q <= 1'b0;
			is_cmd_q <= 1'b0;
			is_read_q <= 1'b0;
			wdata_q <= 8'h00;
			REQ_READY <= 1'b0;
			DONE <= 1'b0;
			ERR <= 1'b0;
			LOCK_STATUS <= nbl_pkg::LS_LOCKED;
			LOCK_EN <= 1'b1;
			WP_N <= 1'b0;
			CE_N <= 1'b1;
		end else begin
			DONE <= 1'b0;
			ERR <= 1'b0;
			req_q <= 1'b0;
			case (st_q)
				S_IDLE: begin
					REQ_READY <= 1'b1;
					if (REQ_VALID) begin
						REQ_READY <= 1'b0;
						op_q <= REQ_OP;
						sa_q <= REQ_START;
						ea_q <= REQ_END;
						step_q <= 4'h0;
						if (REQ_OP == 3'(nbl_pkg::NBL_OP_PROTECT)) begin
							WP_N <= 1'b0;
							wcnt_q <= 4'(nbl_pkg::WP_LOW_CYC);
							st_q <= S_WPLOW;
						end else if (REQ_OP == 3'(nbl_pkg::NBL_OP_UNPROTECT)) begin
							WP_N <= 1'b1;
							st_q <= S_END;
						end else if (REQ_OP == 3'(nbl_pkg::NBL_OP_UNLOCK) && REQ_START > REQ_END) begin
							ERR <= 1'b1;
							st_q <= S_END;
						end else if (REQ_OP == 3'(nbl_pkg::NBL_OP_STATUS) && !rb_s_q) begin
							ERR <= 1'b1;
							st_q <= S_END;
						end else if (REQ_OP > 3'(nbl_pkg::NBL_OP_STATUS)) begin
							ERR <= 1'b1;
							st_q <= S_END;
						end else begin
							CE_N <= 1'b0;
							case (REQ_OP)
								3'(nbl_pkg::NBL_OP_UNLOCK): nsteps_q <= 4'(2 * ADDR_CYCLES + 2);
								3'(nbl_pkg::NBL_OP_STATUS): nsteps_q <= 4'(ADDR_CYCLES + 2);
								default: nsteps_q <= 4'h1;
							endcase
							st_q <= S_ISSUE;
						end
					end
				end
				S_ISSUE: begin
					req_q <= 1'b1;
					is_read_q <= 1'b0;
					is_cmd_q <= 1'b0;
					wdata_q <= addr_sel[8 * ai[1:0] +: 8];
					if (step_q == 4'h0) begin
						is_cmd_q <= 1'b1;
						case (op_q)
							3'(nbl_pkg::NBL_OP_LOCK): wdata_q <= nbl_pkg::OP_LOCK;
							3'(nbl_pkg::NBL_OP_UNLOCK): wdata_q <= nbl_pkg::OP_UNLOCK_SETUP;
							3'(nbl_pkg::NBL_OP_LOCK_DOWN): wdata_q <= nbl_pkg::OP_LOCK_DOWN;
							default: wdata_q <= nbl_pkg::OP_LOCK_STATUS;
						endcase
					end else if (op_q == 3'(nbl_pkg::NBL_OP_UNLOCK) && step_q == 4'(ADDR_CYCLES + 1)) begin
						is_cmd_q <= 1'b1;
						wdata_q <= nbl_pkg::OP_UNLOCK_CONFIRM;
					end else if (op_q == 3'(nbl_pkg::NBL_OP_STATUS) && step_q == nsteps_q - 4'h1) begin
						is_read_q <= 1'b1;
					end
					st_q <= S_WAIT;
				end
				S_WAIT: begin
					if (cyc.done) begin
						if (is_read_q) begin
							LOCK_STATUS <= cyc.rdata[2:0];
						end
						if (step_q == nsteps_q - 4'h1) begin
							CE_N <= 1'b1;
							st_q <= S_END;
						end else begin
							step_q <= step_q + 4'h1;
							st_q <= S_ISSUE;
						end
					end
				end
				S_WPLOW: begin
					if (wcnt_q == 4'h1) begin
						st_q <= S_END;
					end else begin
						wcnt_q <= wcnt_q - 4'h1;
					end
				end
				S_END: begin
					DONE <= 1'b1;
					st_q <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	AST_WP_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
		$fell(WP_N) |-> !WP_N [*5])
		else $error("write protect released before 100ns");
	AST_WP_RESET: assert property (@(posedge CLK) disable iff (!RESETN)
		(st_q == S_IDLE && !REQ_READY && $past(st_q) == S_IDLE) |-> !WP_N)
		else $error("write protect not held low after reset");
	AST_LOCK_EN: assert property (@(posedge CLK) disable iff (!RESETN)
		!CE_N |-> LOCK_EN)
		else $error("lock command issued with lock enable low");
	AST_BUSY: assert property (@(posedge CLK) disable iff (!RESETN)
		(st_q == S_IDLE && REQ_VALID && REQ_OP == 3'(nbl_pkg::NBL_OP_STATUS) && !rb_s_q) |=> ERR)
		else $error("status query not refused while busy");
	AST_RANGE: assert property (@(posedge CLK) disable iff (!RESETN)
		(st_q == S_ISSUE && op_q == 3'(nbl_pkg::NBL_OP_UNLOCK)) |-> sa_q <= ea_q)
		else $error("unlock start above end");
	AST_FIRST_CMD: assert property (@(posedge CLK) disable iff (!RESETN)
		(st_q == S_ISSUE && step_q == 4'h0) |=> (is_cmd_q && !is_read_q))
		else $error("first cycle is not a command");
	AST_CONFIRM: assert property (@(posedge CLK) disable iff (!RESETN)
		(st_q == S_ISSUE && op_q == 3'(nbl_pkg::NBL_OP_UNLOCK) && step_q == 4'(ADDR_CYCLES + 1))
		|=> wdata_q == nbl_pkg::OP_UNLOCK_CONFIRM)
		else $error("unlock confirm out of place");
	AST_STATUS_LEN: assert property (@(posedge CLK) disable iff (!RESETN)
		(st_q == S_ISSUE && op_q == 3'(nbl_pkg::NBL_OP_STATUS)) |-> nsteps_q == 4'(ADDR_CYCLES + 2))
		else $error("status query length wrong");
	AST_DONE: assert property (@(posedge CLK) disable iff (!RESETN)
		(st_q == S_END) |=> DONE && st_q == S_IDLE)
		else $error("done not pulsed");
endmodule // nbl_host
`default_nettype wire

//--- rtl/nbl_pkg.sv
package nbl_pkg;
	// Command opcodes; real values come from the device command table
	localparam logic [7:0] OP_LOCK = 8'h2A;
	localparam logic [7:0] OP_UNLOCK_SETUP = 8'h23;
	localparam logic [7:0] OP_UNLOCK_CONFIRM = 8'h24;
	localparam logic [7:0] OP_LOCK_DOWN = 8'h2C;
	localparam logic [7:0] OP_LOCK_STATUS = 8'h7A;
	// Lock status encodings on I/O2..I/O0
	localparam logic [2:0] LS_LOCKED = 3'h2;
	localparam logic [2:0] LS_UNLOCKED = 3'h6;
	localparam logic [2:0] LS_LOCKED_DOWN = 3'h1;
	localparam logic [2:0] LS_UNLOCKED_LD = 3'h5;
	localparam int PROTECT_STATUS_POS = 7;
	// Bus strobe timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int STROBE_NS = 40;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Write protect low time that clears lock-down
	localparam int WP_LOW_NS = 100;
	localparam int WP_LOW_CYC = (WP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_CYC_BIG = 3;
	localparam int ADDR_CYC_SMALL = 2;
	// Controller operations
	typedef enum logic [2:0] {
		NBL_OP_LOCK = 3'h0,
		NBL_OP_UNLOCK = 3'h1,
		NBL_OP_LOCK_DOWN = 3'h2,
		NBL_OP_STATUS = 3'h3,
		NBL_OP_UNPROTECT = 3'h4,
		NBL_OP_PROTECT = 3'h5
	} nbl_op_t;
endpackage : nbl_pkg

//--- testbench/nand_block_lock_protection_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module nand_block_lock_protection_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic [2:0] req_op = 3'h0;
	logic [23:0] req_start = 24'h00_0000;
	logic [23:0] req_end = 24'h00_0000;
	logic rb = 1'b1;
	logic req_ready, done, err, lock_en, wp_n, ce_n, cle, ale, we_n, re_n, io_oe, dev_oe, seen_err;
	logic [2:0] lock_status;
	logic [7:0] io_out, dev_out, io_bus;
	logic [7:0] io_last = 8'h00;
	logic [63:0] r_unl = '0;
	logic r_ld = 1'b0;
	logic [31:0] seed = 32'h3255_db25;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	int s, e;
	always #10 clk = ~clk;
	// Released bus toggles so a stale value never passes
	assign io_bus = io_oe ? io_out : (dev_oe ? dev_out : ~io_last);
	always @(posedge clk) io_last <= io_bus;
	nbl_host #(.ADDR_CYCLES(3)) i_dut (
		.CLK(clk), .RESETN(rst_n), .REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_START(req_start),
		.REQ_END(req_end), .REQ_READY(req_ready), .DONE(done), .ERR(err), .LOCK_STATUS(lock_status),
		.LOCK_EN(lock_en), .WP_N(wp_n), .CE_N(ce_n), .CLE(cle), .ALE(ale), .WE_N(we_n), .RE_N(re_n),
		.IO_OUT(io_out), .IO_OE(io_oe), .IO_IN(io_bus), .DEVICE_READY_N(rb)
	);
	nbl_dev_model #(.ADDR_CYCLES(3)) i_dev (
		.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .io_in(io_bus),
		.lock_en(lock_en), .wp_n(wp_n), .ready(rb), .io_out(dev_out), .io_oe(dev_oe)
	);
	function automatic int rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return int'(seed[15:0]);
	endfunction
	task automatic report_and_stop();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic run_op(input logic [2:0] op, input logic [23:0] a, input logic [23:0] b, input logic exp_err);
		int k;
		k = 0;
		while (req_ready !== 1'b1 && k < 500) begin
			@(negedge clk);
			k = k + 1;
		end
		req_valid = 1'b1;
		req_op = op;
		req_start = a;
		req_end = b;
		@(negedge clk);
		req_valid = 1'b0;
		seen_err = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 1000) begin
			if (err === 1'b1) seen_err = 1'b1;
			@(negedge clk);
			k = k + 1;
		end
		check({6'h0, done, seen_err}, {6'h0, 1'b1, exp_err});
		if (!exp_err) begin
			case (op)
				nbl_pkg::NBL_OP_LOCK: r_unl = '0;
				nbl_pkg::NBL_OP_UNLOCK: if (!r_ld) for (int i = 0; i < 64; i++) r_unl[i] = i >= a && i <= b;
				nbl_pkg::NBL_OP_LOCK_DOWN: r_ld = 1'b1;
				nbl_pkg::NBL_OP_STATUS: check({5'h0, lock_status}, {5'h0, r_unl[a[5:0]], r_ld ? 2'b01 : 2'b10});
				nbl_pkg::NBL_OP_PROTECT: begin
					r_unl = '0;
					r_ld = 1'b0;
				end
				default: ;
			endcase
		end
	endtask
	task automatic stat(input logic [23:0] a);
		run_op(nbl_pkg::NBL_OP_STATUS, a, 24'h00_0000, 1'b0);
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(negedge clk);
		check({6'h0, wp_n, lock_en}, 8'h01);
		rst_n = 1'b1;
		@(negedge clk);
		run_op(nbl_pkg::NBL_OP_UNPROTECT, 24'h00_0000, 24'h00_0000, 1'b0);
		stat(24'(rnd() % 64));
		for (int i = 0; i < 6; i++) begin
			s = rnd() % 64;
			e = (i == 0) ? s : s + rnd() % (64 - s);
			run_op(nbl_pkg::NBL_OP_UNLOCK, 24'(s), 24'(e), 1'b0);
			stat(24'(s));
			stat(24'((e + 1) % 64));
			stat(24'((s + 63) % 64));
		end
		run_op(nbl_pkg::NBL_OP_UNLOCK, 24'h00_0009, 24'h00_0008, 1'b1);
		run_op(3'h6, 24'h00_0000, 24'h00_0000, 1'b1);
		rb = 1'b0;
		repeat (4) @(negedge clk);
		run_op(nbl_pkg::NBL_OP_STATUS, 24'h00_0000, 24'h00_0000, 1'b1);
		rb = 1'b1;
		repeat (4) @(negedge clk);
		run_op(nbl_pkg::NBL_OP_LOCK, 24'h00_0000, 24'h00_0000, 1'b0);
		stat(24'(s));
		run_op(nbl_pkg::NBL_OP_UNLOCK, 24'h00_000a, 24'h00_0014, 1'b0);
		run_op(nbl_pkg::NBL_OP_LOCK_DOWN, 24'h00_0000, 24'h00_0000, 1'b0);
		run_op(nbl_pkg::NBL_OP_UNLOCK, 24'h00_001e, 24'h00_0028, 1'b0);
		stat(24'h00_000f);
		stat(24'h00_0023);
		run_op(nbl_pkg::NBL_OP_PROTECT, 24'h00_0000, 24'h00_0000, 1'b0);
		run_op(nbl_pkg::NBL_OP_UNPROTECT, 24'h00_0000, 24'h00_0000, 1'b0);
		stat(24'h00_000f);
		run_op(nbl_pkg::NBL_OP_UNLOCK, 24'h00_0003, 24'h00_0003, 1'b0);
		stat(24'h00_0003);
		report_and_stop();
	end
endmodule // nand_block_lock_protection_tb_top
`default_nettype wire

//--- testbench/nbl_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module nbl_dev_model #(
	parameter int ADDR_CYCLES = 3
) (
	input wire logic ce_n, // Chip enable
	input wire logic cle, // Command latch
	input wire logic ale, // Address latch
	input wire logic we_n, // Write enable
	input wire logic re_n, // Read enable
	input wire logic [7:0] io_in, // Bus level
	input wire logic lock_en, // Lock feature enable
	input wire logic wp_n, // Write protect
	input wire logic ready, // Ready/busy level
	output logic [7:0] io_out, // Status byte
	output logic io_oe // Drives the bus
);
	logic [7:0] cmd = 8'h00;
	logic [23:0] sh = 24'h00_0000;
	logic [23:0] st = 24'h00_0000;
	logic [63:0] unl = '0;
	logic ld = 1'b0;
	logic smode = 1'b0;
	logic [2:0] code = 3'h2;
	int n = 0;
	realtime t_wp = 0.0;
	assign io_oe = smode && !ce_n && !re_n;
	assign io_out = {5'h15, code};
	always @(wp_n) begin
		if (!wp_n) begin
			t_wp = $realtime;
			unl = '0;
		end else if ($realtime - t_wp >= 100.0) begin
			ld = 1'b0;
		end
	end
	always @(posedge we_n) begin
		if (!ce_n && cle) begin
			cmd = io_in;
			n = 0;
			smode = 1'b0;
			if (lock_en && cmd == nbl_pkg::OP_LOCK) unl = '0;
			if (lock_en && cmd == nbl_pkg::OP_LOCK_DOWN) ld = 1'b1;
		end else if (!ce_n && ale) begin
			sh[8*n+:8] = io_in;
			n = n + 1;
			if (n == ADDR_CYCLES) begin
				n = 0;
				if (cmd == nbl_pkg::OP_UNLOCK_SETUP) st = sh;
				if (cmd == nbl_pkg::OP_UNLOCK_CONFIRM && lock_en && !ld) begin
					for (int i = 0; i < 64; i++) unl[i] = i >= st && i <= sh;
				end
				if (cmd == nbl_pkg::OP_LOCK_STATUS && lock_en && ready) begin
					code = {unl[sh[5:0]], ld ? 2'b01 : 2'b10};
					smode = 1'b1;
				end
			end
		end
	end
endmodule // nbl_dev_model
`default_nettype wire
